/* pssi_pkg.sv */
`default_nettype none
package pssi_pkg;
    localparam int ADDR_W       = 17;
    localparam int DATA_W       = 36;
    localparam int LANES        = 4;
    localparam int LANE_W       = 9;
    localparam int BURST_LEN    = 4;
    localparam int BURST_W      = 2;
    localparam int PIPE_DEPTH   = 2;
    localparam logic [1:0] BURST_ZERO = 2'h0;
    localparam logic [1:0] BURST_ONE  = 2'h1;
    localparam logic [1:0] BURST_LAST = 2'h3;
endpackage
`default_nettype wire

/* pssi_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface pssi_if;
    logic [pssi_pkg::ADDR_W-1:0] addr;
    logic                        clock_hold_n;
    logic                        read_write_sel;
    logic                        advance_or_load;
    logic                        chip_sel_a_n;
    logic                        chip_sel_b;
    logic                        chip_sel_c_n;
    logic [pssi_pkg::LANES-1:0]  byte_lane_write_n;
    logic                        burst_order_sel;
    logic                        out_drive_en;
    logic [pssi_pkg::DATA_W-1:0] ctl_dq_out;
    logic                        ctl_dq_oe_n;
    logic [pssi_pkg::DATA_W-1:0] mem_dq_out;
    logic                        mem_dq_oe_n;
    logic [pssi_pkg::DATA_W-1:0] dq;
    assign dq = !mem_dq_oe_n ? mem_dq_out : (!ctl_dq_oe_n ? ctl_dq_out : '0);
    modport mem
    (
        input  addr, clock_hold_n, read_write_sel, advance_or_load, chip_sel_a_n, chip_sel_b,
               chip_sel_c_n, byte_lane_write_n, burst_order_sel, out_drive_en, dq,
        output mem_dq_out, mem_dq_oe_n
    );
    modport ctl
    (
        output addr, clock_hold_n, read_write_sel, advance_or_load, chip_sel_a_n, chip_sel_b,
               chip_sel_c_n, byte_lane_write_n, burst_order_sel, out_drive_en, ctl_dq_out, ctl_dq_oe_n,
        input  dq
    );
endinterface
`default_nettype wire

/* pssi_mem.sv */
// Our own choice: the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
module pssi_mem
#(
    parameter int DEPTH = 64
)
(
    input  wire logic   clock,
    input  wire logic   nrst,
    input  wire logic   ce,
    pssi_if.mem         bus,
    output logic [pssi_pkg::ADDR_W-1:0] wr_addr,
    output logic [pssi_pkg::DATA_W-1:0] wr_data,
    output logic [pssi_pkg::LANES-1:0]  wr_lane_n,
    output logic                        wr_strobe,
    output logic                        selected
);
    localparam int IDX_W = $clog2(DEPTH);
    logic [pssi_pkg::DATA_W-1:0] mem_reg [DEPTH];
    // stage 0: access of this edge; stage 1 and 2: data phase pipeline
    logic                        act_reg [pssi_pkg::PIPE_DEPTH+1];
    logic                        wr_reg  [pssi_pkg::PIPE_DEPTH+1];
    logic [pssi_pkg::ADDR_W-1:0] ad_reg  [pssi_pkg::PIPE_DEPTH+1];
    logic [pssi_pkg::LANES-1:0]  bl_reg  [pssi_pkg::PIPE_DEPTH+1];
    logic [pssi_pkg::ADDR_W-1:0] base_reg;
    logic [pssi_pkg::BURST_W-1:0] cnt_reg;
    logic                        burst_reg;
    logic                        bwr_reg;
    logic [pssi_pkg::DATA_W-1:0] q_reg;
    logic                        q_oe_n_reg;
    logic [pssi_pkg::DATA_W-1:0] dq_s1_reg;
    logic                        wr_strobe_reg, sel_reg;
    logic [pssi_pkg::ADDR_W-1:0] wr_addr_reg;
    logic [pssi_pkg::DATA_W-1:0] wr_data_reg;
    logic [pssi_pkg::LANES-1:0]  wr_lane_reg;
    wire edge_en = ce && !bus.clock_hold_n;
    wire sel_ok  = !bus.chip_sel_a_n && bus.chip_sel_b && !bus.chip_sel_c_n;
    wire load    = !bus.advance_or_load;
    wire new_acc = load && sel_ok;
    // burst advance needs the chip still selected
    wire adv     = !load && sel_ok && burst_reg && (cnt_reg != pssi_pkg::BURST_LAST);
    wire [pssi_pkg::BURST_W-1:0] cnt_next = cnt_reg + pssi_pkg::BURST_ONE;
    wire [pssi_pkg::BURST_W-1:0] low_lin  = base_reg[pssi_pkg::BURST_W-1:0] + cnt_next;
    wire [pssi_pkg::BURST_W-1:0] low_int  = base_reg[pssi_pkg::BURST_W-1:0] ^ cnt_next;
    wire [pssi_pkg::BURST_W-1:0] low_sel  = bus.burst_order_sel ? low_int : low_lin;
    wire [pssi_pkg::ADDR_W-1:0]  adv_addr = {base_reg[pssi_pkg::ADDR_W-1:pssi_pkg::BURST_W], low_sel};
    wire s0_act = new_acc || adv;
    wire s0_wr  = new_acc ? !bus.read_write_sel : bwr_reg;
    wire [pssi_pkg::ADDR_W-1:0] s0_ad = new_acc ? bus.addr : adv_addr;
    wire last_act = act_reg[pssi_pkg::PIPE_DEPTH];
    wire last_wr  = wr_reg[pssi_pkg::PIPE_DEPTH];
    wire [IDX_W-1:0] last_idx = ad_reg[pssi_pkg::PIPE_DEPTH][IDX_W-1:0];
    wire [IDX_W-1:0] rd_idx   = ad_reg[pssi_pkg::PIPE_DEPTH-1][IDX_W-1:0];
    wire rd_now = act_reg[pssi_pkg::PIPE_DEPTH-1] && !wr_reg[pssi_pkg::PIPE_DEPTH-1];
    wire do_write = last_act && last_wr;
    wire wr_fire  = edge_en && do_write;
    // a read of the word written at this edge takes the merged word
    wire rd_hit   = do_write && (last_idx == rd_idx);
    logic [pssi_pkg::DATA_W-1:0] merged;
    wire [pssi_pkg::DATA_W-1:0] rd_word = rd_hit ? merged : mem_reg[rd_idx];
    // write data sampled at the edge before the write stage
    always_comb
    begin
        merged = mem_reg[last_idx];
        for (int i = 0; i < pssi_pkg::LANES; i++)
        begin
            if (!bl_reg[pssi_pkg::PIPE_DEPTH][i])
                merged[i*pssi_pkg::LANE_W +: pssi_pkg::LANE_W] = dq_s1_reg[i*pssi_pkg::LANE_W +: pssi_pkg::LANE_W];
        end
    end
    // sampling runs on held edges too; the controller keeps its data standing
    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
        begin
            dq_s1_reg <= '0;
        end
        else if (ce)
        begin
            dq_s1_reg <= bus.dq;
        end
    end
    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
        begin
            burst_reg <= 1'b0;
            bwr_reg   <= 1'b0;
            cnt_reg   <= pssi_pkg::BURST_ZERO;
            base_reg  <= '0;
        end
        else if (edge_en)
        begin
            if (load)
            begin
                burst_reg <= sel_ok;
                bwr_reg   <= !bus.read_write_sel;
                cnt_reg   <= pssi_pkg::BURST_ZERO;
                base_reg  <= bus.addr;
            end
            // a deselected edge ends any burst
            else if (!sel_ok)
                burst_reg <= 1'b0;
            else if (adv)
                cnt_reg <= cnt_next;
        end
    end
    // pipeline: deselect stops new access but older stages drain
    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
        begin
            for (int i = 0; i <= pssi_pkg::PIPE_DEPTH; i++)
            begin
                act_reg[i] <= 1'b0;
                wr_reg[i]  <= 1'b0;
                ad_reg[i]  <= '0;
                bl_reg[i]  <= '1;
            end
        end
        else if (edge_en)
        begin
            act_reg[0] <= s0_act;
            wr_reg[0]  <= s0_wr;
            ad_reg[0]  <= s0_ad;
            bl_reg[0]  <= bus.byte_lane_write_n;
            for (int i = 1; i <= pssi_pkg::PIPE_DEPTH; i++)
            begin
                act_reg[i] <= act_reg[i-1];
                wr_reg[i]  <= wr_reg[i-1];
                ad_reg[i]  <= ad_reg[i-1];
                bl_reg[i]  <= bl_reg[i-1];
            end
        end
    end
    always_ff @(posedge clock)
    begin
        if (edge_en && do_write)
            mem_reg[last_idx] <= merged;
    end
    // read data drives in the access stage two; float after deselect or write
    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
        begin
            q_reg      <= '0;
            q_oe_n_reg <= 1'b1;
        end
        else if (edge_en)
        begin
            q_reg      <= rd_word;
            q_oe_n_reg <= !rd_now;
        end
    end
    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
            wr_strobe_reg <= 1'b0;
        else if (ce)
            wr_strobe_reg <= wr_fire;
    end
    // last array write, held for reading
    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
        begin
            wr_addr_reg <= '0;
            wr_data_reg <= '0;
            wr_lane_reg <= '1;
        end
        else if (wr_fire)
        begin
            wr_addr_reg <= ad_reg[pssi_pkg::PIPE_DEPTH];
            wr_data_reg <= merged;
            wr_lane_reg <= bl_reg[pssi_pkg::PIPE_DEPTH];
        end
    end
    // select state of the last edge taken
    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
            sel_reg <= 1'b0;
        else if (edge_en)
            sel_reg <= sel_ok;
    end
    assign bus.mem_dq_out  = q_reg;
    assign bus.mem_dq_oe_n = q_oe_n_reg || !bus.out_drive_en;
    assign wr_addr   = wr_addr_reg;
    assign wr_data   = wr_data_reg;
    assign wr_lane_n = wr_lane_reg;
    assign wr_strobe = wr_strobe_reg;
    assign selected  = sel_reg;
endmodule // pssi_mem
`default_nettype wire

/* pssi_ctl.sv */
`timescale 1ns/1ps
`default_nettype none
module pssi_ctl
(
    input  wire logic                        clock,
    input  wire logic                        nrst,
    input  wire logic                        ce,
    pssi_if.ctl                              bus,
    input  wire logic                        req_valid,
    input  wire logic                        req_write,
    input  wire logic                        req_burst,
    input  wire logic                        req_hold,
    input  wire logic                        req_desel,
    input  wire logic                        req_order,
    input  wire logic                        req_drive,
    input  wire logic [pssi_pkg::ADDR_W-1:0] req_addr,
    input  wire logic [pssi_pkg::LANES-1:0]  req_lane_n,
    input  wire logic [pssi_pkg::DATA_W-1:0] req_wdata,
    output logic                             rd_valid,
    output logic [pssi_pkg::DATA_W-1:0]      rd_data
);
    logic [pssi_pkg::ADDR_W-1:0] addr_reg;
    logic hold_n_reg, rw_reg, adv_reg, csa_reg, csb_reg, order_reg, drive_reg;
    logic [pssi_pkg::LANES-1:0]  bl_reg;
    logic [pssi_pkg::BURST_W-1:0] beats_reg;
    logic                        bwr_reg;
    logic                        wr_pipe_reg [pssi_pkg::PIPE_DEPTH];
    logic                        rd_pipe_reg [pssi_pkg::PIPE_DEPTH];
    logic                        rd_tail_reg [pssi_pkg::PIPE_DEPTH];
    logic [pssi_pkg::DATA_W-1:0] wd_pipe_reg [pssi_pkg::PIPE_DEPTH];
    logic [pssi_pkg::DATA_W-1:0] dq_reg, rd_data_reg;
    logic                        dq_oe_n_reg, rd_valid_reg;
    wire bursting = beats_reg != pssi_pkg::BURST_ZERO;
    wire issue    = req_valid && !req_hold && !bursting;
    wire beat_wr  = issue ? req_write : (bursting && bwr_reg);
    wire beat_rd  = issue ? !req_write : (bursting && !bwr_reg);
    wire beat_on  = issue ? !req_desel : bursting;
    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
        begin
            addr_reg  <= '0;
            hold_n_reg <= 1'b0;
            rw_reg    <= 1'b1;
            adv_reg   <= 1'b0;
            csa_reg   <= 1'b1;
            csb_reg   <= 1'b0;
            bl_reg    <= '1;
            order_reg <= 1'b0;
            drive_reg <= 1'b0;
            beats_reg <= pssi_pkg::BURST_ZERO;
            bwr_reg   <= 1'b0;
        end
        else if (ce)
        begin
            hold_n_reg <= req_hold;
            order_reg  <= req_order;
            drive_reg  <= req_drive;
            if (!req_hold)
            begin
                adv_reg <= !issue;
                csa_reg <= !beat_on;
                csb_reg <= beat_on;
                bl_reg  <= (beat_wr && beat_on) ? req_lane_n : '1;
                if (issue)
                begin
                    addr_reg  <= req_addr;
                    rw_reg    <= !req_write;
                    bwr_reg   <= req_write;
                    beats_reg <= (req_burst && !req_desel) ? pssi_pkg::BURST_LAST : pssi_pkg::BURST_ZERO;
                end
                else if (bursting)
                    beats_reg <= beats_reg - pssi_pkg::BURST_ONE;
            end
        end
    end
    // data follows its command by two edges
    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
        begin
            for (int i = 0; i < pssi_pkg::PIPE_DEPTH; i++)
            begin
                wr_pipe_reg[i] <= 1'b0;
                rd_pipe_reg[i] <= 1'b0;
                rd_tail_reg[i] <= 1'b0;
                wd_pipe_reg[i] <= '0;
            end
            dq_reg       <= '0;
            dq_oe_n_reg  <= 1'b1;
            rd_valid_reg <= 1'b0;
            rd_data_reg  <= '0;
        end
        else if (ce)
        begin
            rd_valid_reg <= 1'b0;
            if (!req_hold)
            begin
                wr_pipe_reg[0] <= beat_wr && beat_on;
                rd_pipe_reg[0] <= beat_rd && beat_on;
                wd_pipe_reg[0] <= req_wdata;
                wr_pipe_reg[1] <= wr_pipe_reg[0];
                rd_pipe_reg[1] <= rd_pipe_reg[0];
                wd_pipe_reg[1] <= wd_pipe_reg[0];
                dq_reg      <= wd_pipe_reg[1];
                dq_oe_n_reg <= !wr_pipe_reg[1];
            end
            // read capture follows the memory's own held edges
            if (!hold_n_reg)
            begin
                rd_tail_reg[0] <= rd_pipe_reg[1];
                rd_tail_reg[1] <= rd_tail_reg[0];
                rd_valid_reg   <= rd_tail_reg[1];
                rd_data_reg    <= bus.dq;
            end
        end
    end
    assign bus.addr              = addr_reg;
    assign bus.clock_hold_n      = hold_n_reg;
    assign bus.read_write_sel    = rw_reg;
    assign bus.advance_or_load   = adv_reg;
    assign bus.chip_sel_a_n      = csa_reg;
    assign bus.chip_sel_b        = csb_reg;
    assign bus.chip_sel_c_n      = csa_reg;
    assign bus.byte_lane_write_n = bl_reg;
    assign bus.burst_order_sel   = order_reg;
    assign bus.out_drive_en      = drive_reg;
    assign bus.ctl_dq_out        = dq_reg;
    assign bus.ctl_dq_oe_n       = dq_oe_n_reg;
    assign rd_valid = rd_valid_reg;
    assign rd_data  = rd_data_reg;
endmodule // pssi_ctl
`default_nettype wire

/* pssi_properties.sv */
`timescale 1ns/1ps
`default_nettype none
module pssi_properties
(
    input wire logic                        clock,
    input wire logic                        nrst,
    input wire logic                        clock_hold_n,
    input wire logic                        read_write_sel,
    input wire logic                        advance_or_load,
    input wire logic                        chip_sel_a_n,
    input wire logic                        chip_sel_b,
    input wire logic                        chip_sel_c_n,
    input wire logic                        out_drive_en,
    input wire logic                        ctl_dq_oe_n,
    input wire logic                        mem_dq_oe_n,
    input wire logic [pssi_pkg::DATA_W-1:0] mem_dq_out
);
    wire sel  = !chip_sel_a_n && chip_sel_b && !chip_sel_c_n;
    wire run  = !clock_hold_n;
    wire load = run && !advance_or_load;
    default clocking cb @(posedge clock); endclocking
    default disable iff (!nrst);
    sequence read_load;  load && sel && read_write_sel;  endsequence
    sequence write_load; load && sel && !read_write_sel; endsequence
    sequence desel_load; load && !sel;                   endsequence
    sequence two_runs;   run ##1 run;                    endsequence
    a_read_drives: assert property (read_load ##1 two_runs |=> !out_drive_en || !mem_dq_oe_n)
        else $error("read data not driven");
    a_write_quiet: assert property (write_load ##1 two_runs |=> mem_dq_oe_n)
        else $error("memory drives during write data");
    a_write_data: assert property (write_load ##1 two_runs |-> !ctl_dq_oe_n)
        else $error("write data missing two edges after load");
    a_desel_float: assert property (desel_load ##1 two_runs |=> mem_dq_oe_n)
        else $error("bus not floated after deselect");
    a_drive_gate: assert property (!out_drive_en |-> mem_dq_oe_n)
        else $error("memory drives with output drive off");
    a_one_driver: assert property (mem_dq_oe_n || ctl_dq_oe_n)
        else $error("both ends drive the bus");
    a_hold_freeze: assert property ((clock_hold_n && out_drive_en) ##1 out_drive_en
        |-> $stable(mem_dq_oe_n) && (mem_dq_oe_n || $stable(mem_dq_out)))
        else $error("output changed on held edge");
    a_burst_beat: assert property (read_load ##1 (run && advance_or_load && sel) ##1 two_runs
        |=> !out_drive_en || !mem_dq_oe_n)
        else $error("burst beat not driven");
endmodule  // pssi_properties
`default_nettype wire

/* test_pipelined_sync_sram_interface.sv */
`timescale 1ns/1ps
`default_nettype none
module test_pipelined_sync_sram_interface;
    typedef struct packed
    {
        logic                        write;
        logic                        burst;
        logic                        order;
        logic [7:0]                  addr;
        logic [pssi_pkg::LANES-1:0]  lane_n;
        logic [pssi_pkg::DATA_W-1:0] data;
    } pssi_row_type;
    pssi_row_type                rows [8] = '{
        '{1'b1, 1'b0, 1'b0, 8'h05, 4'h0, 36'h123456789}, '{1'b1, 1'b0, 1'b0, 8'h05, 4'hA, 36'hFEDCBA987},
        '{1'b0, 1'b0, 1'b0, 8'h05, 4'hF, 36'h0}, '{1'b1, 1'b1, 1'b0, 8'h0A, 4'h0, 36'h111111110},
        '{1'b0, 1'b1, 1'b0, 8'h0A, 4'hF, 36'h0}, '{1'b0, 1'b1, 1'b1, 8'h09, 4'hF, 36'h0},
        '{1'b1, 1'b1, 1'b1, 8'h11, 4'h0, 36'h222222220}, '{1'b0, 1'b1, 1'b0, 8'h12, 4'hF, 36'h0}};
    logic                        clock = 1'b0;
    logic                        nrst = 1'b0;
    logic                        req_valid = 1'b0, req_write = 1'b0, req_burst = 1'b0, req_hold = 1'b0;
    logic                        req_desel = 1'b0, req_order = 1'b0, req_drive = 1'b1;
    logic [pssi_pkg::ADDR_W-1:0] req_addr = '0;
    logic [pssi_pkg::LANES-1:0]  req_lane_n = '1;
    logic [pssi_pkg::DATA_W-1:0] req_wdata = '0;
    logic                        rd_valid, wr_strobe, selected;
    logic [pssi_pkg::DATA_W-1:0] rd_data, wr_data;
    logic [pssi_pkg::ADDR_W-1:0] wr_addr;
    logic [pssi_pkg::LANES-1:0]  wr_lane_n;
    logic [pssi_pkg::DATA_W-1:0] model [64];
    logic [pssi_pkg::DATA_W-1:0] exp_wd[$], exp_rd[$];
    logic [pssi_pkg::ADDR_W-1:0] exp_wa[$];
    logic [pssi_pkg::LANES-1:0]  exp_wl[$];
    int                          bad_count = 0, comparisons = 0, cycles = 0;
    pssi_if bus_if();
    pssi_mem #(.DEPTH(64)) pssi_mem_inst (.clock(clock), .nrst(nrst), .ce(1'b1), .bus(bus_if.mem),
        .wr_addr(wr_addr), .wr_data(wr_data), .wr_lane_n(wr_lane_n), .wr_strobe(wr_strobe), .selected(selected));
    pssi_ctl pssi_ctl_inst (.clock(clock), .nrst(nrst), .ce(1'b1), .bus(bus_if.ctl), .req_valid(req_valid),
        .req_write(req_write), .req_burst(req_burst), .req_hold(req_hold), .req_desel(req_desel),
        .req_order(req_order), .req_drive(req_drive), .req_addr(req_addr), .req_lane_n(req_lane_n),
        .req_wdata(req_wdata), .rd_valid(rd_valid), .rd_data(rd_data));
    pssi_properties pssi_properties_inst (.clock(clock), .nrst(nrst), .clock_hold_n(bus_if.clock_hold_n),
        .read_write_sel(bus_if.read_write_sel), .advance_or_load(bus_if.advance_or_load),
        .chip_sel_a_n(bus_if.chip_sel_a_n), .chip_sel_b(bus_if.chip_sel_b), .chip_sel_c_n(bus_if.chip_sel_c_n),
        .out_drive_en(bus_if.out_drive_en), .ctl_dq_oe_n(bus_if.ctl_dq_oe_n), .mem_dq_oe_n(bus_if.mem_dq_oe_n),
        .mem_dq_out(bus_if.mem_dq_out));
    always #10 clock = ~clock;
    function automatic logic [pssi_pkg::DATA_W-1:0] mask(input logic [pssi_pkg::LANES-1:0] ln);
        logic [pssi_pkg::DATA_W-1:0] m;
        m = '0;
        for (int k = 0; k < pssi_pkg::LANES; k++)
            if (!ln[k])
                m[k*pssi_pkg::LANE_W+:pssi_pkg::LANE_W] = '1;
        return m;
    endfunction
    task automatic check(input logic ok, input string msg);
        comparisons++;
        if (ok !== 1'b1)
        begin
            bad_count++;
            $display("BAD %0t %s", $time, msg);
        end
    endtask
    task automatic tally_and_finish;
        $display("comparisons %0d bad_count %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    // queues expectations, then issues; burst data follows each beat edge
    task automatic op(input pssi_row_type r, input logic desel);
        int                          i;
        logic [1:0]                  b;
        logic [pssi_pkg::ADDR_W-1:0] a;
        logic [pssi_pkg::DATA_W-1:0] d;
        for (i = 0; i < (r.burst ? 4 : 1); i++)
        begin
            b = r.order ? (r.addr[1:0] ^ i[1:0]) : (r.addr[1:0] + i[1:0]);
            a = pssi_pkg::ADDR_W'({r.addr[7:2], b});
            d = r.data + pssi_pkg::DATA_W'(i);
            if (!desel && r.write)
            begin
                model[a[5:0]] = (model[a[5:0]] & ~mask(r.lane_n)) | (d & mask(r.lane_n));
                exp_wa.push_back(a);
                exp_wd.push_back(d);
                exp_wl.push_back(r.lane_n);
            end
            else if (!desel)
                exp_rd.push_back(model[a[5:0]]);
        end
        req_valid <= 1'b1;
        req_write <= r.write;
        req_burst <= r.burst;
        req_order <= r.order;
        req_desel <= desel;
        req_addr <= pssi_pkg::ADDR_W'(r.addr);
        req_lane_n <= r.lane_n;
        req_wdata <= r.data;
        @(posedge clock);
        if (r.burst)
        begin
            req_valid <= 1'b0;
            for (i = 1; i < 4; i++)
            begin
                req_wdata <= r.data + pssi_pkg::DATA_W'(i);
                @(posedge clock);
            end
        end
    endtask
    task automatic idle(input int n);
        req_valid <= 1'b0;
        repeat (n) @(posedge clock);
    endtask
    always @(posedge clock)
    begin
        if (wr_strobe === 1'b1)
        begin
            check(exp_wa.size() != 0, "unexpected array write");
            if (exp_wa.size() != 0)
            begin
                check(wr_addr === exp_wa[0], "write address");
                check((wr_data & mask(exp_wl[0])) === (exp_wd[0] & mask(exp_wl[0])), "write data");
                check(wr_lane_n === exp_wl[0], "write lanes");
                void'(exp_wa.pop_front());
                void'(exp_wd.pop_front());
                void'(exp_wl.pop_front());
            end
        end
        if (rd_valid === 1'b1)
        begin
            check(exp_rd.size() != 0, "unexpected read data");
            if (exp_rd.size() != 0)
                check(rd_data === exp_rd.pop_front(), "read data");
        end
    end
    always @(posedge clock)
    begin
        cycles = cycles + 1;
        if (cycles == 2000)
        begin
            bad_count++;
            tally_and_finish();
        end
    end
    initial
    begin
        repeat (5) @(posedge clock);
        check(bus_if.mem_dq_oe_n === 1'b1, "bus driven in reset");
        nrst <= 1'b1;
        for (int k = 0; k < 8; k++)
        begin
            op(rows[k], 1'b0);
            idle(8);
        end
        op(pssi_row_type'{1'b1, 1'b0, 1'b0, 8'h20, 4'h0, 36'h0ABCDEF01}, 1'b0);
        op(pssi_row_type'{1'b0, 1'b0, 1'b0, 8'h20, 4'hF, 36'h0}, 1'b0);
        op(pssi_row_type'{1'b0, 1'b0, 1'b0, 8'h21, 4'hF, 36'h0}, 1'b1);
        idle(2);
        check(selected === 1'b0, "still selected");
        idle(8);
        op(rows[5], 1'b0);
        req_hold <= 1'b1;
        @(posedge clock);
        req_hold <= 1'b0;
        idle(10);
        req_drive <= 1'b0;
        idle(3);
        req_drive <= 1'b1;
        idle(10);
        check(exp_wa.size() == 0 && exp_rd.size() == 0, "transfers missing");
        tally_and_finish();
    end
endmodule  // test_pipelined_sync_sram_interface
`default_nettype wire
